// *** design/status_two_pkg.sv ***
// constants for the second transceiver status register and its companions
// Notes on behaviour
// [R1] writing 1 to bit 7 clears temperature error only below 125 degC
// [R2] bit 6 forces the two-wire input filter fast, else filter follows protocol
// [R3] listener_selected (bit 4) sets once a select or polling command is answered
// [R4] listener_selected sets only during auto anticollision in passive mode
// [R5] listener_selected clears itself when the external field goes away
// [R6] while card_cipher_active (bit 3) is set the cipher unit is enabled
// [R7] card_cipher_active sets only on a successful card authenticate command
// [R8] card_cipher_active means something only in reader mode toward cipher cards
// [R9] host clears card_cipher_active by writing 0; hardware never clears it
// [R10] engine state reads 000 when idle, 001 waiting for transmit_trigger
// [R11] 010 pre-send: waits field if enabled, stays at least tx_wait_time
// [R12] 100 pre-receive: waits field if enabled, stays at least rx_wait_time
// [R13] engine state 011 sending, 101 waiting for data, 110 receiving
// [R14] writing 1 to transmit_trigger starts sending, leaving wait-for-start
// [R15] code 111 never reported; reserved bit 5 reads zero
package status_two_pkg;

   // byte addresses on the bus
   localparam logic [7:0] STATUS2_ADDR     = 8'h08;
   localparam logic [7:0] ENGINE_CTRL_ADDR = 8'h0C;
   localparam logic [7:0] TX_WAIT_ADDR     = 8'h10;
   localparam logic [7:0] RX_WAIT_ADDR     = 8'h14;
   localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h18;
   localparam logic [7:0] IRQ_MASK_ADDR    = 8'h1C;

   // status field positions
   localparam int TEMP_CLR_BIT   = 7;
   localparam int FORCE_FAST_BIT = 6;
   localparam int LISTENER_BIT   = 4;
   localparam int CIPHER_BIT     = 3;

   // engine control field positions
   localparam int CTRL_TX_RF_BIT   = 0;
   localparam int CTRL_RX_RF_BIT   = 1;
   localparam int CTRL_TRIGGER_BIT = 7;

   // interrupt bits
   localparam int IRQ_W          = 4;
   localparam int IRQ_TEMP_BIT   = 0;
   localparam int IRQ_LISTEN_BIT = 1;
   localparam int IRQ_CIPHER_BIT = 2;
   localparam int IRQ_RXDONE_BIT = 3;

   // reset values
   localparam logic [7:0]       STATUS2_RESET = 8'h00;
   localparam logic [7:0]       CTRL_RESET    = 8'h00;
   localparam logic [7:0]       WAIT_RESET    = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET     = 4'h0;

   // engine state codes as reported
   localparam logic [2:0] CODE_IDLE       = 3'h0;
   localparam logic [2:0] CODE_WAIT_START = 3'h1;
   localparam logic [2:0] CODE_PRE_SEND   = 3'h2;
   localparam logic [2:0] CODE_SENDING    = 3'h3;
   localparam logic [2:0] CODE_PRE_RECV   = 3'h4;
   localparam logic [2:0] CODE_WAIT_DATA  = 3'h5;
   localparam logic [2:0] CODE_RECEIVING  = 3'h6;
   localparam logic [2:0] CODE_UNUSED     = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_START, ST_PRE_SEND, ST_SENDING,
      ST_PRE_RECV, ST_WAIT_DATA, ST_RECEIVING
   } engine_state_t;

endpackage

// *** design/status_two_regs.sv ***
// second transceiver status register, engine state machine and wishbone slave
`timescale 1ns/1ps
`default_nettype none
module status_two_regs #(
   parameter int WAIT_W = 8
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        transceive_active,
   input  wire logic        temp_over_limit,
   input  wire logic        temp_below_limit,
   input  wire logic        rf_field_on,
   input  wire logic        auto_anticoll_running,
   input  wire logic        passive_mode,
   input  wire logic        target_answered,
   input  wire logic        auth_done_ok,
   input  wire logic        tx_frame_done,
   input  wire logic        rx_frame_start,
   input  wire logic        rx_frame_end,
   output logic             filter_fast,
   output logic             cipher_enable,
   output logic             temp_error,
   output logic [2:0]       link_engine_state,
   output logic             irq
);
   import status_two_pkg::*;

   logic                     ack_ff, nxt_ack;
   logic [31:0]              dat_ff, nxt_dat;
   logic                     clr_bit_ff, nxt_clr_bit;
   logic                     fast_ff, nxt_fast;
   logic                     listener_ff, nxt_listener;
   logic                     cipher_ff, nxt_cipher;
   logic                     temp_err_ff, nxt_temp_err;
   logic                     tx_rf_ff, nxt_tx_rf;
   logic                     rx_rf_ff, nxt_rx_rf;
   logic [WAIT_W-1:0]        tx_wait_ff, nxt_tx_wait;
   logic [WAIT_W-1:0]        rx_wait_ff, nxt_rx_wait;
   logic [IRQ_W-1:0]         irq_stat_ff, nxt_irq_stat;
   logic [IRQ_W-1:0]         irq_mask_ff, nxt_irq_mask;
   logic                     irq_ff, nxt_irq;
   engine_state_t            state_ff, nxt_state;
   logic [2:0]               code_ff, nxt_code;
   logic [WAIT_W-1:0]        cnt_ff, nxt_cnt;
   logic                     wr_en, rd_start, trigger, rx_done_evt;
   logic [IRQ_W-1:0]         events;
   logic [7:0]               status2_view;

   // write lands on the edge where the master sees ack; read data is
   // captured one edge earlier so it is stable while ack is high
   assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
   assign rd_start = wb_cyc_i && wb_stb_i && !ack_ff;
   assign trigger  = wr_en && (wb_adr_i == ENGINE_CTRL_ADDR)
                     && wb_dat_i[CTRL_TRIGGER_BIT];
   assign rx_done_evt = (state_ff == ST_RECEIVING) && rx_frame_end;
   assign status2_view = {clr_bit_ff, fast_ff, 1'b0, listener_ff,
                          cipher_ff, code_ff}; // see [R15]

   // bus slave and register file next values
   always_comb begin
      nxt_ack      = rd_start;
      nxt_dat      = dat_ff;
      nxt_clr_bit  = clr_bit_ff;
      nxt_fast     = fast_ff;
      nxt_tx_rf    = tx_rf_ff;
      nxt_rx_rf    = rx_rf_ff;
      nxt_tx_wait  = tx_wait_ff;
      nxt_rx_wait  = rx_wait_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_temp_err = temp_err_ff;
      nxt_listener = listener_ff;
      nxt_cipher   = cipher_ff;
      if (rd_start) begin
         // unmapped addresses still ack, reading zero
         nxt_dat = 32'h0000_0000;
         if (wb_adr_i == STATUS2_ADDR) begin
            nxt_dat[7:0] = status2_view;
         end else if (wb_adr_i == ENGINE_CTRL_ADDR) begin
            nxt_dat[CTRL_TX_RF_BIT] = tx_rf_ff;
            nxt_dat[CTRL_RX_RF_BIT] = rx_rf_ff;
         end else if (wb_adr_i == TX_WAIT_ADDR) begin
            nxt_dat[WAIT_W-1:0] = tx_wait_ff;
         end else if (wb_adr_i == RX_WAIT_ADDR) begin
            nxt_dat[WAIT_W-1:0] = rx_wait_ff;
         end else if (wb_adr_i == IRQ_STATUS_ADDR) begin
            nxt_dat[IRQ_W-1:0] = irq_stat_ff;
         end else if (wb_adr_i == IRQ_MASK_ADDR) begin
            nxt_dat[IRQ_W-1:0] = irq_mask_ff;
         end
      end
      if (wr_en) begin
         if (wb_adr_i == STATUS2_ADDR) begin
            nxt_clr_bit = wb_dat_i[TEMP_CLR_BIT];
            nxt_fast    = wb_dat_i[FORCE_FAST_BIT]; // see [R2]
            // software may only drop the cipher flag, never raise it
            if (!wb_dat_i[CIPHER_BIT]) begin
               nxt_cipher = 1'b0; // see [R9]
            end
            if (wb_dat_i[TEMP_CLR_BIT] && temp_below_limit) begin
               nxt_temp_err = 1'b0; // see [R1]
            end
         end else if (wb_adr_i == ENGINE_CTRL_ADDR) begin
            nxt_tx_rf = wb_dat_i[CTRL_TX_RF_BIT];
            nxt_rx_rf = wb_dat_i[CTRL_RX_RF_BIT];
         end else if (wb_adr_i == TX_WAIT_ADDR) begin
            nxt_tx_wait = wb_dat_i[WAIT_W-1:0];
         end else if (wb_adr_i == RX_WAIT_ADDR) begin
            nxt_rx_wait = wb_dat_i[WAIT_W-1:0];
         end else if (wb_adr_i == IRQ_STATUS_ADDR) begin
            nxt_irq_stat = irq_stat_ff & ~wb_dat_i[IRQ_W-1:0];
         end else if (wb_adr_i == IRQ_MASK_ADDR) begin
            nxt_irq_mask = wb_dat_i[IRQ_W-1:0];
         end
      end
      // hardware sets win over software clears
      if (temp_over_limit) begin
         nxt_temp_err = 1'b1;
      end
      if (auth_done_ok) begin
         nxt_cipher = 1'b1; // see [R7]
      end
      // field loss beats a late answer: no field, no selection
      if (!rf_field_on) begin
         nxt_listener = 1'b0; // see [R5]
      end else if (target_answered && auto_anticoll_running && passive_mode) begin
         nxt_listener = 1'b1; // see [R3] see [R4]
      end
      // listener and cipher events read the flag next values, so they live here to keep one comb path
      events                 = IRQ_RESET;
      events[IRQ_TEMP_BIT]   = temp_over_limit && !temp_err_ff;
      events[IRQ_LISTEN_BIT] = nxt_listener && !listener_ff;
      events[IRQ_CIPHER_BIT] = nxt_cipher && !cipher_ff;
      events[IRQ_RXDONE_BIT] = rx_done_evt;
      nxt_irq_stat = nxt_irq_stat | events;
      nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ack_ff      <= 1'b0;
         dat_ff      <= 32'h0000_0000;
         clr_bit_ff  <= STATUS2_RESET[TEMP_CLR_BIT];
         fast_ff     <= STATUS2_RESET[FORCE_FAST_BIT];
         listener_ff <= STATUS2_RESET[LISTENER_BIT];
         cipher_ff   <= STATUS2_RESET[CIPHER_BIT];
         temp_err_ff <= 1'b0;
         tx_rf_ff    <= CTRL_RESET[CTRL_TX_RF_BIT];
         rx_rf_ff    <= CTRL_RESET[CTRL_RX_RF_BIT];
         tx_wait_ff  <= WAIT_RESET[WAIT_W-1:0];
         rx_wait_ff  <= WAIT_RESET[WAIT_W-1:0];
         irq_stat_ff <= IRQ_RESET;
         irq_mask_ff <= IRQ_RESET;
         irq_ff      <= 1'b0;
      end else begin
         ack_ff      <= nxt_ack;
         dat_ff      <= nxt_dat;
         clr_bit_ff  <= nxt_clr_bit;
         fast_ff     <= nxt_fast;
         listener_ff <= nxt_listener;
         cipher_ff   <= nxt_cipher;
         temp_err_ff <= nxt_temp_err;
         tx_rf_ff    <= nxt_tx_rf;
         rx_rf_ff    <= nxt_rx_rf;
         tx_wait_ff  <= nxt_tx_wait;
         rx_wait_ff  <= nxt_rx_wait;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff      <= nxt_irq;
      end
   end

   // transmit/receive engine; dropping the command aborts to idle
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      if (cnt_ff != {WAIT_W{1'b1}}) begin
         nxt_cnt = cnt_ff + 1'b1; // saturating dwell counter
      end
      case (state_ff)
         ST_IDLE: begin
            if (transceive_active) begin
               nxt_state = ST_WAIT_START;
            end
         end
         ST_WAIT_START: begin
            if (trigger) begin
               nxt_state = ST_PRE_SEND; // see [R14]
               nxt_cnt   = '0;
            end
         end
         ST_PRE_SEND: begin
            // dwell of tx_wait_time+1 cycles keeps the minimum even at zero
            if (cnt_ff >= tx_wait_ff && (!tx_rf_ff || rf_field_on)) begin
               nxt_state = ST_SENDING; // see [R11]
            end
         end
         ST_SENDING: begin
            if (tx_frame_done) begin
               nxt_state = ST_PRE_RECV;
               nxt_cnt   = '0;
            end
         end
         ST_PRE_RECV: begin
            if (cnt_ff >= rx_wait_ff && (!rx_rf_ff || rf_field_on)) begin
               nxt_state = ST_WAIT_DATA; // see [R12]
            end
         end
         ST_WAIT_DATA: begin
            if (rx_frame_start) begin
               nxt_state = ST_RECEIVING;
            end
         end
         ST_RECEIVING: begin
            if (rx_frame_end) begin
               nxt_state = ST_WAIT_START;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (!transceive_active) begin
         nxt_state = ST_IDLE;
      end
      case (nxt_state)
         ST_WAIT_START: nxt_code = CODE_WAIT_START; // see [R10]
         ST_PRE_SEND:   nxt_code = CODE_PRE_SEND;
         ST_SENDING:    nxt_code = CODE_SENDING; // see [R13]
         ST_PRE_RECV:   nxt_code = CODE_PRE_RECV;
         ST_WAIT_DATA:  nxt_code = CODE_WAIT_DATA;
         ST_RECEIVING:  nxt_code = CODE_RECEIVING;
         default:       nxt_code = CODE_IDLE; // see [R15]
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         code_ff  <= CODE_IDLE;
         cnt_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         code_ff  <= nxt_code;
         cnt_ff   <= nxt_cnt;
      end
   end

   // outputs straight from flops; cipher is meaningful only in reader mode
   assign wb_ack_o          = ack_ff;
   assign wb_dat_o          = dat_ff;
   assign filter_fast       = fast_ff;
   assign cipher_enable     = cipher_ff; // see [R6] see [R8]
   assign temp_error        = temp_err_ff;
   assign link_engine_state = code_ff;
   assign irq               = irq_ff;

   // checks
   a_ack_single_pulse: assert property (@(posedge clock) disable iff (reset)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   a_ack_answers_req: assert property (@(posedge clock) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_engine_abort: assert property (@(posedge clock) disable iff (reset) // see [R10]
      !transceive_active |=> link_engine_state == CODE_IDLE)
      else $error("engine not idle after command dropped");
   a_code_not_seven: assert property (@(posedge clock) disable iff (reset) // see [R15]
      link_engine_state != CODE_UNUSED) else $error("unused engine code seen");
   a_reserved_reads_zero: assert property (@(posedge clock) disable iff (reset) // see [R15]
      (wb_ack_o && $past(wb_adr_i) == STATUS2_ADDR) |-> !wb_dat_o[5])
      else $error("reserved bit reads one");
   a_listener_set_cause: assert property (@(posedge clock) disable iff (reset) // see [R4]
      $rose(listener_ff) |-> $past(target_answered && auto_anticoll_running
                                   && passive_mode && rf_field_on))
      else $error("listener flag set without answered anticollision");
   a_listener_field_off: assert property (@(posedge clock) disable iff (reset) // see [R5]
      !rf_field_on |=> !listener_ff) else $error("listener flag survived field loss");
   a_cipher_set_cause: assert property (@(posedge clock) disable iff (reset) // see [R7]
      $rose(cipher_enable) |-> $past(auth_done_ok))
      else $error("cipher enabled without authentication");
   a_temp_clear_gate: assert property (@(posedge clock) disable iff (reset) // see [R1]
      (wr_en && wb_adr_i == STATUS2_ADDR && wb_dat_i[TEMP_CLR_BIT] && !temp_below_limit
       && temp_error) |=> temp_error) else $error("temp error cleared while hot");
   a_filter_follows: assert property (@(posedge clock) disable iff (reset) // see [R2]
      (wr_en && wb_adr_i == STATUS2_ADDR) |=> filter_fast == $past(wb_dat_i[FORCE_FAST_BIT]))
      else $error("filter mode not updated");
   a_trigger_starts: assert property (@(posedge clock) disable iff (reset) // see [R14]
      (state_ff == ST_WAIT_START && trigger && transceive_active)
      |=> link_engine_state == CODE_PRE_SEND) else $error("trigger did not start send");
   a_send_to_recv: assert property (@(posedge clock) disable iff (reset) // see [R13]
      (state_ff == ST_SENDING && tx_frame_done && transceive_active)
      |=> link_engine_state == CODE_PRE_RECV) else $error("send end not followed by rx wait");
   a_tx_field_hold: assert property (@(posedge clock) disable iff (reset) // see [R11]
      (state_ff == ST_PRE_SEND && tx_rf_ff && !rf_field_on && transceive_active)
      |=> link_engine_state == CODE_PRE_SEND) else $error("left pre-send without field");

endmodule // status_two_regs
`default_nettype wire

// *** tb/host_model.sv ***
// wishbone master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        clock,
   input  wire logic        wb_ack_o,
   input  wire logic [31:0] wb_dat_o,
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [7:0]       wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i
);
   // bus idle from time zero
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
   end
   // one classic cycle; no latency assumed, the bench watchdog ends a hang
   task automatic access(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= wd;
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // released address, data and we lines show the inverse; sel keeps its last value
      wb_adr_i <= ~adr;
      wb_dat_i <= ~wd;
      wb_we_i  <= ~we;
   endtask
endmodule // host_model
`default_nettype wire

// *** tb/transceiver_status_two_bench.sv ***
// self-checking bench for the second transceiver status register
`timescale 1ns/1ps
`default_nettype none
module transceiver_status_two_bench;
   import status_two_pkg::*;
   logic clock = 1'b0, reset = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic transceive_active = 0, temp_over_limit = 0, temp_below_limit = 0;
   logic rf_field_on = 1, auto_anticoll_running = 0, passive_mode = 0;
   logic target_answered = 0, auth_done_ok = 0, tx_frame_done = 0;
   logic rx_frame_start = 0, rx_frame_end = 0;
   logic filter_fast, cipher_enable, temp_error, irq;
   logic [2:0] link_engine_state;
   int checks = 0, mismatches = 0;

   always #25 clock = ~clock;

   status_two_regs #(.WAIT_W(8)) dut_u (.clock, .reset, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .transceive_active, .temp_over_limit, .temp_below_limit, .rf_field_on,
      .auto_anticoll_running, .passive_mode, .target_answered, .auth_done_ok,
      .tx_frame_done, .rx_frame_start, .rx_frame_end, .filter_fast,
      .cipher_enable, .temp_error, .link_engine_state, .irq);

   host_model host_u (.clock, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i);

   // comparison, reporting and closing helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic flag(input logic s, input logic e);
      check({31'h0, s}, {31'h0, e});
   endtask
   task automatic code(input logic [2:0] e);
      check({29'h0, link_engine_state}, {29'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      host_u.access(1'b0, a, 32'h0, r);
      check(r, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      host_u.access(1'b1, a, d, r);
   endtask
   // bounded wait for an engine code, then judge it
   task automatic wait_code(input logic [2:0] e, input int n);
      for (int i = 0; i < n && link_engine_state !== e; i++) @(posedge clock);
      code(e);
   endtask
   task automatic answer;
      target_answered <= 1'b1;
      tick(1);
      target_answered <= 1'b0;
      tick(2);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // reset values, unmapped read, reserved bit
   task automatic t_reset;
      rd(STATUS2_ADDR, 32'h0);
      rd(8'h3C, 32'h0);
      check({28'h0, filter_fast, cipher_enable, temp_error, irq}, 32'h0);
      code(CODE_IDLE);
      wr(STATUS2_ADDR, 32'h60);
      tick(1);
      flag(filter_fast, 1'b1);
      rd(STATUS2_ADDR, 32'h40);
      wr(STATUS2_ADDR, 32'h0);
      tick(1);
      flag(filter_fast, 1'b0);
   endtask
   // clear attempted while hot must not take
   task automatic t_temp;
      temp_over_limit <= 1'b1;
      tick(1);
      temp_over_limit <= 1'b0;
      tick(2);
      flag(temp_error, 1'b1);
      wr(STATUS2_ADDR, 32'h80);
      tick(1);
      flag(temp_error, 1'b1);
      temp_below_limit <= 1'b1;
      wr(STATUS2_ADDR, 32'h80);
      tick(1);
      flag(temp_error, 1'b0);
      wr(STATUS2_ADDR, 32'h0);
   endtask
   // selection only counts in passive anticollision
   task automatic t_listen;
      answer();
      rd(STATUS2_ADDR, 32'h0);
      auto_anticoll_running <= 1'b1;
      answer();
      rd(STATUS2_ADDR, 32'h0);
      passive_mode <= 1'b1;
      answer();
      rd(STATUS2_ADDR, 32'h10);
      rf_field_on <= 1'b0;
      tick(2);
      rd(STATUS2_ADDR, 32'h0);
      auto_anticoll_running <= 1'b0;
      passive_mode <= 1'b0;
   endtask
   // cipher flag: hardware sets, host clears
   task automatic t_cipher;
      wr(STATUS2_ADDR, 32'h08);
      rd(STATUS2_ADDR, 32'h0);
      auth_done_ok <= 1'b1;
      tick(1);
      auth_done_ok <= 1'b0;
      tick(2);
      rd(STATUS2_ADDR, 32'h08);
      flag(cipher_enable, 1'b1);
      wr(STATUS2_ADDR, 32'h0);
      tick(1);
      flag(cipher_enable, 1'b0);
   endtask
   // full transfer walk with field wait, dwell and frame-received interrupt
   task automatic t_engine;
      wr(IRQ_STATUS_ADDR, 32'hF);
      rd(IRQ_STATUS_ADDR, 32'h0);
      wr(TX_WAIT_ADDR, 32'h4);
      wr(RX_WAIT_ADDR, 32'h6);
      wr(ENGINE_CTRL_ADDR, 32'h80);
      tick(2);
      code(CODE_IDLE);
      transceive_active <= 1'b1;
      wait_code(CODE_WAIT_START, 4);
      wr(ENGINE_CTRL_ADDR, 32'h81);
      tick(1);
      code(CODE_PRE_SEND);
      tick(8);
      code(CODE_PRE_SEND);
      rf_field_on <= 1'b1;
      wait_code(CODE_SENDING, 4);
      tx_frame_done <= 1'b1;
      tick(1);
      tx_frame_done <= 1'b0;
      tick(1);
      code(CODE_PRE_RECV);
      tick(4);
      code(CODE_PRE_RECV);
      wait_code(CODE_WAIT_DATA, 8);
      rx_frame_start <= 1'b1;
      tick(1);
      rx_frame_start <= 1'b0;
      tick(1);
      code(CODE_RECEIVING);
      rx_frame_end <= 1'b1;
      tick(1);
      rx_frame_end <= 1'b0;
      tick(1);
      code(CODE_WAIT_START);
      rd(IRQ_STATUS_ADDR, 32'h8);
      flag(irq, 1'b0);
      wr(IRQ_MASK_ADDR, 32'h8);
      tick(2);
      flag(irq, 1'b1);
      wr(IRQ_STATUS_ADDR, 32'h8);
      tick(2);
      flag(irq, 1'b0);
      transceive_active <= 1'b0;
      tick(2);
      code(CODE_IDLE);
   endtask

   // main sequence; first request only after reset is seen low
   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      tick(1);
      t_reset();
      t_temp();
      t_listen();
      t_cipher();
      t_engine();
      close_out();
   end
   // watchdog: far beyond the fewer than 200 cycles the tests need
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      close_out();
   end
endmodule // transceiver_status_two_bench
`default_nettype wire
